/* logic/pkt_link_consts.svh */
// constants for the packet header and message link handler
`ifndef PKT_LINK_CONSTS_SVH
`define PKT_LINK_CONSTS_SVH
`define NODE_ID_W          4
`define NODE_ID_HOST       4'h0
`define NODE_ID_DEFAULT    4'hf
`define KIND_CONTROL       3'h0
`define KIND_DATA_CMD      3'h1
`define KIND_RESPONSE      3'h2
`define KIND_DATA          3'h3
`define KIND_MESSAGE       3'h7
`define CAT_LINK           3'h0
`define CAT_INTERRUPT      3'h3
`define CAT_APP            3'h4
`define IDX_FLOW_REQUEST   4'h0
`define IDX_FLOW_READY     4'h1
`define IDX_BURST_STATUS   4'h2
`define CODE_FATAL_BIT     7
`define CODE_RETRY_BIT     0
`define CODE_FLOW_RSVD     7'h00
`define CODE_STATUS_RSVD   6'h00
`define WORD_W             30
`define W_NATIVE           29
`define W_KIND             28:26
`define W_DEST             25:22
`define W_SRC              21:18
`define W_TAG              17:15
`define W_CAT              14:12
`define W_IDX              11:8
`define W_CODE             7:0
`endif

/* logic/pkt_link_pkg.sv */
// types for the packet header and message link handler
package pkt_link_pkg;
  typedef enum logic [2:0] {
    TX_IDLE   = 3'b001,
    TX_FIRST  = 3'b010,
    TX_SECOND = 3'b100
  } tx_state_type;
endpackage

/* logic/pkt_link_handler.sv */
// device-side packet header routing and duplicated message handling
//
// Contract
// - node id 0..15, zero only for host
// - reset id 15, then take assigned 1..15
// - native flag 1; messages always set it
// - header: kind, dest, src, transaction tag
// - reserved bits sent zero, ignored on receive
// - kind codes: control,data cmd,response,data,message
// - src equals dest is broadcast, control only
// - foreign non-broadcast packets forwarded unchanged, unprocessed; corrupted or bad-header ones are dropped and flagged instead
// - broadcast processed locally and also forwarded
// - message: category, index, code fields
// - link category: request, ready, burst status
// - category 3 interrupt, 4 application, others reserved
// - flow messages: code bit 7 fatal
// - status: bit 7 fatal, bit 0 retryable
// - fatal flag held until abort or completion
// - retryable-only status after burst triggers retry
// - every message sent twice back to back
// - accept either valid copy, both bad errors
// - fatal: bad header, backend fault, retries exhausted
// - retryable: framing or crc failure
// - errors reported to host in messages
`timescale 1ns/1ps
`include "pkt_link_consts.svh"

module pkt_link_handler #(
  parameter int MAX_RETRY = 3
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        node_id_load,
  input  wire logic [3:0]  node_id_value,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic        rx_native_packet_flag,
  input  wire logic [2:0]  rx_packet_kind,
  input  wire logic [3:0]  rx_dest_node,
  input  wire logic [3:0]  rx_src_node,
  input  wire logic [2:0]  rx_transaction_tag,
  input  wire logic [2:0]  rx_message_category,
  input  wire logic [3:0]  rx_message_index,
  input  wire logic [7:0]  rx_message_code,
  input  wire logic        rx_crc_error,
  input  wire logic        rx_frame_error,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [`WORD_W-1:0] tx_word,
  input  wire logic        tx_msg_req,
  input  wire logic [3:0]  tx_msg_index,
  input  wire logic [3:0]  tx_msg_dest,
  input  wire logic [2:0]  tx_msg_tag,
  output logic             tx_msg_busy,
  input  wire logic        backend_fault,
  input  wire logic        xact_end,
  output logic [3:0]       node_id,
  output logic             local_valid,
  output logic [`WORD_W-1:0] local_word,
  output logic             flow_request_msg,
  output logic             flow_ready_msg,
  output logic             burst_status_msg,
  output logic             app_msg_valid,
  output logic             retry_burst,
  output logic             peer_fatal,
  output logic             msg_rx_error,
  output logic             fatal_fault_flag,
  output logic             retryable_fault_flag,
  output logic             bad_header_fault,
  output logic             retries_exhausted_fault
);

  if (MAX_RETRY < 1 || MAX_RETRY > 255) begin : g_retry_check
    $error("MAX_RETRY must be 1..255");
  end
  localparam logic [7:0] RETRY_LIMIT = 8'(MAX_RETRY);
  pkt_link_pkg::tx_state_type tx_state_r;
  logic [3:0]           node_id_r;
  logic [3:0]           msg_index_r;
  logic [3:0]           msg_dest_r;
  logic [2:0]           msg_tag_r;
  logic [7:0]           retry_count_r;
  logic                 dup_wait_r;
  logic                 dup_done_r;
  logic                 fatal_r;
  logic                 retryable_r;
  logic                 bad_header_r;
  logic                 exhausted_r;
  logic                 local_valid_r;
  logic [`WORD_W-1:0]   local_word_r;
  logic                 flow_req_r;
  logic                 flow_rdy_r;
  logic                 status_r;
  logic                 app_r;
  logic                 retry_r;
  logic                 peer_fatal_r;
  logic                 msg_err_r;
  logic                 out_valid_r;
  logic [`WORD_W-1:0]   out_word_r;
  logic                 skid_valid_r;
  logic [`WORD_W-1:0]   skid_word_r;
  logic                 buf_in_ready;
  logic                 buf_push;
  logic [`WORD_W-1:0]   buf_in_word;
  logic                 rx_take;
  logic                 rx_bad;
  logic                 kind_reserved;
  logic                 broadcast;
  logic                 for_me;
  logic                 illegal;
  logic                 forward;
  logic                 is_msg;
  logic                 msg_ok;
  logic                 msg_deliver;
  logic                 msg_push;
  logic [7:0]           msg_code;
  logic [`WORD_W-1:0]   rx_word;
  logic [`WORD_W-1:0]   msg_word;
  logic                 retry_hit;

  assign rx_word = {rx_native_packet_flag, rx_packet_kind, rx_dest_node, rx_src_node,
                    rx_transaction_tag, rx_message_category, rx_message_index,
                    rx_message_code};
  assign kind_reserved = !(rx_packet_kind == `KIND_CONTROL || rx_packet_kind == `KIND_DATA_CMD ||
                           rx_packet_kind == `KIND_RESPONSE || rx_packet_kind == `KIND_DATA ||
                           rx_packet_kind == `KIND_MESSAGE);
  assign rx_bad = rx_crc_error | rx_frame_error;
  assign broadcast = (rx_src_node == rx_dest_node) &&
                     (rx_packet_kind == `KIND_CONTROL);
  // a message without the native flag, or a non-control src==dest, is a bad header
  assign illegal = !rx_bad && (kind_reserved ||
                   (rx_packet_kind == `KIND_MESSAGE && !rx_native_packet_flag) ||
                   (rx_src_node == rx_dest_node && !broadcast));
  assign for_me = (rx_dest_node == node_id_r) || broadcast;
  // corrupted packets are never forwarded: their routing fields cannot be trusted
  assign forward = !rx_bad && !illegal &&
                   ((rx_dest_node != node_id_r) || broadcast);
  assign is_msg = rx_packet_kind == `KIND_MESSAGE && rx_dest_node == node_id_r;
  assign msg_ok = is_msg && !rx_bad && !illegal;
  assign rx_take = rx_valid && rx_ready;

  // a failed first copy is rescued by the second; a good first makes the second moot
  assign msg_deliver = rx_take && msg_ok && !(dup_wait_r && dup_done_r);

  // outgoing message, reserved bits zero
  assign msg_code = (msg_index_r == `IDX_BURST_STATUS) ?
                    {fatal_r, `CODE_STATUS_RSVD, retryable_r} :
                    {fatal_r, `CODE_FLOW_RSVD};
  assign msg_word = {1'b1, `KIND_MESSAGE, msg_dest_r, node_id_r, msg_tag_r,
                     `CAT_LINK, msg_index_r, msg_code};

  // message copies own the buffer input so the two copies leave with no gap
  assign msg_push = (tx_state_r != pkt_link_pkg::TX_IDLE) && buf_in_ready;
  assign rx_ready = buf_in_ready && (tx_state_r == pkt_link_pkg::TX_IDLE);
  assign buf_push = msg_push || (rx_take && forward);
  assign buf_in_word = msg_push ? msg_word : rx_word;

  always_ff @(posedge clock) begin
    if (srst) begin
      node_id_r <= `NODE_ID_DEFAULT;
    end else if (node_id_load && node_id_value != `NODE_ID_HOST) begin
      node_id_r <= node_id_value;
    end
  end

  // message transmit sequencer
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_state_r  <= pkt_link_pkg::TX_IDLE;
      msg_index_r <= `IDX_FLOW_REQUEST;
      msg_dest_r  <= `NODE_ID_HOST;
      msg_tag_r   <= 3'h0;
    end else begin
      unique case (tx_state_r)
        pkt_link_pkg::TX_IDLE: begin
          if (tx_msg_req) begin
            tx_state_r  <= pkt_link_pkg::TX_FIRST;
            msg_index_r <= tx_msg_index;
            msg_dest_r  <= tx_msg_dest;
            msg_tag_r   <= tx_msg_tag;
          end
        end
        pkt_link_pkg::TX_FIRST: begin
          if (msg_push) begin
            tx_state_r <= pkt_link_pkg::TX_SECOND;
          end
        end
        pkt_link_pkg::TX_SECOND: begin
          if (msg_push) begin
            tx_state_r <= pkt_link_pkg::TX_IDLE;
          end
        end
        default: begin
          tx_state_r <= pkt_link_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // duplicate tracking on received messages
  always_ff @(posedge clock) begin
    if (srst) begin
      dup_wait_r <= 1'b0;
      dup_done_r <= 1'b0;
      msg_err_r  <= 1'b0;
    end else begin
      msg_err_r <= 1'b0;
      if (rx_take && is_msg) begin
        dup_wait_r <= !dup_wait_r;
        dup_done_r <= dup_wait_r ? 1'b0 : msg_ok;
        msg_err_r  <= dup_wait_r && !dup_done_r && !msg_ok;
      end
    end
  end

  // local delivery and link message decode
  assign retry_hit = msg_deliver && rx_message_category == `CAT_LINK &&
                     rx_message_index == `IDX_BURST_STATUS &&
                     rx_message_code[`CODE_RETRY_BIT] && !rx_message_code[`CODE_FATAL_BIT];
  always_ff @(posedge clock) begin
    if (srst) begin
      local_valid_r <= 1'b0;
      local_word_r  <= '0;
      flow_req_r    <= 1'b0;
      flow_rdy_r    <= 1'b0;
      status_r      <= 1'b0;
      app_r         <= 1'b0;
      retry_r       <= 1'b0;
      peer_fatal_r  <= 1'b0;
    end else begin
      local_valid_r <= rx_take && for_me && !rx_bad && !illegal && !is_msg;
      if (rx_take) begin
        local_word_r <= rx_word;
      end
      flow_req_r   <= msg_deliver && rx_message_category == `CAT_LINK &&
                      rx_message_index == `IDX_FLOW_REQUEST;
      flow_rdy_r   <= msg_deliver && rx_message_category == `CAT_LINK &&
                      rx_message_index == `IDX_FLOW_READY;
      status_r     <= msg_deliver && rx_message_category == `CAT_LINK &&
                      rx_message_index == `IDX_BURST_STATUS;
      // interrupt and reserved categories are dropped
      app_r        <= msg_deliver && rx_message_category == `CAT_APP;
      retry_r      <= retry_hit;
      peer_fatal_r <= msg_deliver && rx_message_category == `CAT_LINK &&
                      rx_message_index <= `IDX_BURST_STATUS &&
                      rx_message_code[`CODE_FATAL_BIT];
    end
  end

  // error classes; a set in the clearing cycle wins
  always_ff @(posedge clock) begin
    if (srst) begin
      bad_header_r  <= 1'b0;
      exhausted_r   <= 1'b0;
      retry_count_r <= 8'h00;
    end else begin
      if (xact_end) begin
        bad_header_r  <= 1'b0;
        exhausted_r   <= 1'b0;
        retry_count_r <= 8'h00;
      end
      if (rx_take && illegal) begin
        bad_header_r <= 1'b1;
      end
      if (retry_hit) begin
        if (retry_count_r + 8'h01 >= RETRY_LIMIT) begin
          exhausted_r <= 1'b1;
        end
        retry_count_r <= retry_count_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      fatal_r <= 1'b0;
    end else if ((rx_take && illegal) || backend_fault || (exhausted_r && !xact_end)) begin
      fatal_r <= 1'b1;
    end else if (xact_end) begin
      fatal_r <= 1'b0;
    end
  end

  // burst errors are reported once in the next status message
  always_ff @(posedge clock) begin
    if (srst) begin
      retryable_r <= 1'b0;
    end else if (rx_take && rx_bad) begin
      retryable_r <= 1'b1;
    end else if (xact_end || (msg_push && tx_state_r == pkt_link_pkg::TX_SECOND &&
                              msg_index_r == `IDX_BURST_STATUS)) begin
      retryable_r <= 1'b0;
    end
  end

  // two-entry skid buffer toward the next node
  assign buf_in_ready = !skid_valid_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      out_valid_r  <= 1'b0;
      out_word_r   <= '0;
      skid_valid_r <= 1'b0;
      skid_word_r  <= '0;
    end else if (!out_valid_r || tx_ready) begin
      if (skid_valid_r) begin
        out_word_r   <= skid_word_r;
        skid_valid_r <= 1'b0;
      end else begin
        out_valid_r <= buf_push;
        out_word_r  <= buf_in_word;
      end
    end else if (buf_push) begin
      skid_valid_r <= 1'b1;
      skid_word_r  <= buf_in_word;
    end
  end

  assign tx_valid                = out_valid_r;
  assign tx_word                 = out_word_r;
  assign tx_msg_busy             = tx_state_r != pkt_link_pkg::TX_IDLE;
  assign node_id                 = node_id_r;
  assign local_valid             = local_valid_r;
  assign local_word              = local_word_r;
  assign flow_request_msg        = flow_req_r;
  assign flow_ready_msg          = flow_rdy_r;
  assign burst_status_msg        = status_r;
  assign app_msg_valid           = app_r;
  assign retry_burst             = retry_r;
  assign peer_fatal              = peer_fatal_r;
  assign msg_rx_error            = msg_err_r;
  assign fatal_fault_flag        = fatal_r;
  assign retryable_fault_flag    = retryable_r;
  assign bad_header_fault        = bad_header_r;
  assign retries_exhausted_fault = exhausted_r;

endmodule // pkt_link_handler

/* bench/link_checker_assertions.sv */
// port assertions for the packet link handler
`timescale 1ns/1ps
module link_checker (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        node_id_load,
  input wire logic [3:0]  node_id_value,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic [2:0]  rx_packet_kind,
  input wire logic [3:0]  rx_dest_node,
  input wire logic [3:0]  rx_src_node,
  input wire logic        rx_crc_error,
  input wire logic        rx_frame_error,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [29:0] tx_word,
  input wire logic        tx_msg_req,
  input wire logic        tx_msg_busy,
  input wire logic        backend_fault,
  input wire logic        xact_end,
  input wire logic [3:0]  node_id,
  input wire logic        local_valid,
  input wire logic        fatal_fault_flag,
  input wire logic        retryable_fault_flag,
  input wire logic        bad_header_fault
);
  logic take;
  logic clean;
  assign take = rx_valid && rx_ready;
  assign clean = take && !rx_crc_error && !rx_frame_error;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_msg_start;
    tx_msg_req && !tx_msg_busy;
  endsequence
  sequence s_msg_done;
    tx_msg_busy ##[1:60] !tx_msg_busy;
  endsequence
  a_reset_id: assert property (disable iff (1'b0) srst |=> node_id == 4'hf)
    else $error("node id not default after reset");
  a_id_nonzero: assert property (node_id != 4'h0)
    else $error("device node id is zero");
  a_id_load: assert property (node_id_load && node_id_value != 4'h0 |=>
    node_id == $past(node_id_value)) else $error("node id not loaded");
  a_own_local: assert property (clean && rx_packet_kind == 3'h0 && rx_dest_node == node_id
    |=> local_valid) else $error("own control packet not delivered");
  a_foreign_drop: assert property (take && rx_dest_node != node_id &&
    rx_src_node != rx_dest_node |=> !local_valid) else $error("foreign packet delivered");
  a_bcast_local: assert property (clean && rx_packet_kind == 3'h0 &&
    rx_src_node == rx_dest_node |=> local_valid) else $error("broadcast not delivered");
  a_crc_retry: assert property (take && rx_crc_error |=> retryable_fault_flag)
    else $error("crc error did not set retryable flag");
  a_bad_kind: assert property (clean && rx_packet_kind inside {3'h4, 3'h5, 3'h6}
    |=> bad_header_fault) else $error("reserved kind not flagged");
  a_backend_fatal: assert property (backend_fault |=> fatal_fault_flag)
    else $error("backend fault not fatal");
  a_fatal_hold: assert property (fatal_fault_flag && !xact_end |=> fatal_fault_flag)
    else $error("fatal flag dropped early");
  a_tx_stall: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word))
    else $error("stalled word changed");
  a_msg_native: assert property (tx_valid && tx_word[28:26] == 3'h7 |-> tx_word[29])
    else $error("message without native flag");
  a_msg_pair: assert property (s_msg_start |=> s_msg_done)
    else $error("message copies not finished");
endmodule // link_checker

/* bench/link_peer.sv */
// next-node model: sinks outgoing words, aborts a transaction on a fatal flag
`timescale 1ns/1ps
module link_peer (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [1:0]  mode,
  input  wire logic        tx_valid,
  input  wire logic [29:0] tx_word,
  output logic             tx_ready,
  output logic             abort_req
);
  logic [29:0] got [0:15];
  int          cnt;
  // mode 0 prompt, 1 every other cycle, 2 stopped; a slow sink must lose nothing
  always_ff @(posedge clock) begin
    tx_ready <= !srst && (mode == 2'h0 || (mode == 2'h1 && !tx_ready));
  end
  always_ff @(posedge clock) begin
    abort_req <= 1'b0;
    if (srst) begin
      cnt <= 0;
    end else if (tx_valid && tx_ready) begin
      got[cnt[3:0]] <= tx_word;
      cnt <= cnt + 1;
      // a fatal link message ends the transaction at once
      abort_req <= tx_word[28:26] == 3'h7 && tx_word[14:12] == 3'h0 && tx_word[7];
    end
  end
endmodule // link_peer

/* bench/testbench.sv */
// self-checking bench for the packet link handler
`timescale 1ns/1ps
module testbench;
  logic        clock, srst, node_id_load, rx_valid, rx_ready, rx_native_packet_flag;
  logic        rx_crc_error, rx_frame_error, tx_valid, tx_ready, tx_msg_req, tx_msg_busy;
  logic        backend_fault, xact_end, xact_cmd, abort_req, local_valid, flow_request_msg;
  logic        flow_ready_msg, burst_status_msg, app_msg_valid, retry_burst, peer_fatal;
  logic        msg_rx_error, fatal_fault_flag, retryable_fault_flag, bad_header_fault;
  logic        retries_exhausted_fault;
  logic [1:0]  mode;
  logic [2:0]  rx_packet_kind, rx_transaction_tag, rx_message_category, tx_msg_tag;
  logic [3:0]  node_id_value, rx_dest_node, rx_src_node, rx_message_index;
  logic [3:0]  tx_msg_index, tx_msg_dest, node_id;
  logic [7:0]  rx_message_code;
  logic [29:0] tx_word, local_word;
  int          error_cnt, checked, cycles, base;
  assign xact_end = xact_cmd | abort_req;
  pkt_link_handler #(.MAX_RETRY(3)) pkt_link_handler_inst (.*);
  link_peer link_peer_inst (.clock(clock), .srst(srst), .mode(mode), .tx_valid(tx_valid),
    .tx_word(tx_word), .tx_ready(tx_ready), .abort_req(abort_req));
  task automatic chkb(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chkw(input string n, input logic [29:0] e, input logic [29:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  function automatic logic [29:0] pk(input logic [2:0] k, input logic [3:0] d,
    input logic [3:0] s, input logic [2:0] c, input logic [3:0] i, input logic [7:0] code);
    return {1'b1, k, d, s, 3'h2, c, i, code};
  endfunction
  // returns just after the taking edge, while the packet's pulses stand
  task automatic send(input logic [29:0] w, input logic [1:0] e);
    step(1);
    {rx_native_packet_flag, rx_packet_kind, rx_dest_node, rx_src_node, rx_transaction_tag,
      rx_message_category, rx_message_index, rx_message_code} = w;
    {rx_frame_error, rx_crc_error} = e;
    rx_valid = 1'b1;
    while (rx_ready !== 1'b1) step(1);
    step(1);
    rx_valid = 1'b0;
  endtask
  task automatic pulse_xact;
    xact_cmd = 1'b1;
    step(1);
    xact_cmd = 1'b0;
    step(1);
  endtask
  task automatic load(input logic [3:0] v);
    node_id_value = v;
    node_id_load = 1'b1;
    step(1);
    node_id_load = 1'b0;
    step(1);
  endtask
  task automatic t_node_id;
    chkw("node id", 30'h0000_000f, {26'h000_0000, node_id});
    load(4'h0);
    chkw("node id", 30'h0000_000f, {26'h000_0000, node_id});
    load(4'h5);
    chkw("node id", 30'h0000_0005, {26'h000_0000, node_id});
  endtask
  task automatic t_local;
    base = link_peer_inst.cnt;
    for (int k = 0; k < 4; k++) begin
      send(pk(3'(k), 4'h5, 4'h0, 3'h0, 4'h0, 8'h00), 2'h0);
      chkb("local valid", 1'b1, local_valid);
      chkw("local word", pk(3'(k), 4'h5, 4'h0, 3'h0, 4'h0, 8'h00), local_word);
    end
    step(4);
    chkw("pops", 30'h0000_0000, 30'(link_peer_inst.cnt - base));
  endtask
  // a stopped sink fills both buffer entries; the third packet must wait
  task automatic t_forward;
    mode = 2'h2;
    base = link_peer_inst.cnt;
    send(pk(3'h1, 4'h3, 4'h0, 3'h0, 4'h0, 8'h00), 2'h0);
    chkb("local valid", 1'b0, local_valid);
    send(pk(3'h3, 4'h3, 4'h0, 3'h0, 4'h0, 8'h00), 2'h0);
    chkb("rx ready", 1'b0, rx_ready);
    mode = 2'h1;
    send(pk(3'h0, 4'h9, 4'h9, 3'h0, 4'h0, 8'h00), 2'h0);
    chkb("broadcast local", 1'b1, local_valid);
    step(12);
    chkw("pops", 30'h0000_0003, 30'(link_peer_inst.cnt - base));
    chkw("fwd 1", pk(3'h1, 4'h3, 4'h0, 3'h0, 4'h0, 8'h00), link_peer_inst.got[base]);
    chkw("fwd 2", pk(3'h3, 4'h3, 4'h0, 3'h0, 4'h0, 8'h00), link_peer_inst.got[base+1]);
    chkw("fwd 3", pk(3'h0, 4'h9, 4'h9, 3'h0, 4'h0, 8'h00), link_peer_inst.got[base+2]);
  endtask
  task automatic t_errors;
    for (int k = 4; k < 7; k++) begin
      send(pk(3'(k), 4'h5, 4'h0, 3'h0, 4'h0, 8'h00), 2'h0);
      chkb("bad header", 1'b1, bad_header_fault);
      step(4);
      chkb("fatal held", 1'b1, fatal_fault_flag);
      pulse_xact();
      chkb("fatal cleared", 1'b0, fatal_fault_flag);
    end
    for (int e = 1; e < 3; e++) begin
      send(pk(3'h0, 4'h5, 4'h0, 3'h0, 4'h0, 8'h00), 2'(e));
      chkb("corrupt local", 1'b0, local_valid);
      chkb("retryable", 1'b1, retryable_fault_flag);
      pulse_xact();
    end
  endtask
  task automatic t_msg_rx;
    for (int i = 0; i < 3; i++) begin
      send(pk(3'h7, 4'h5, 4'h0, 3'h0, 4'h2, 8'h01), 2'h0);
      chkb("retry pulse", 1'b1, retry_burst);
      chkb("status pulse", 1'b1, burst_status_msg);
      send(pk(3'h7, 4'h5, 4'h0, 3'h0, 4'h2, 8'h01), 2'h0);
      chkb("second copy", 1'b0, retry_burst);
    end
    step(1);
    chkb("exhausted", 1'b1, retries_exhausted_fault);
    chkb("fatal", 1'b1, fatal_fault_flag);
    pulse_xact();
    chkb("fatal cleared", 1'b0, fatal_fault_flag);
    send(pk(3'h7, 4'h5, 4'h0, 3'h0, 4'h0, 8'h80), 2'h1);
    send(pk(3'h7, 4'h5, 4'h0, 3'h0, 4'h0, 8'h80), 2'h0);
    chkb("flow request", 1'b1, flow_request_msg);
    chkb("peer fatal", 1'b1, peer_fatal);
    send(pk(3'h7, 4'h5, 4'h0, 3'h0, 4'h1, 8'h00), 2'h0);
    chkb("flow ready", 1'b1, flow_ready_msg);
    send(pk(3'h7, 4'h5, 4'h0, 3'h0, 4'h1, 8'h00), 2'h0);
    send(pk(3'h7, 4'h5, 4'h0, 3'h4, 4'h0, 8'h00), 2'h0);
    chkb("app message", 1'b1, app_msg_valid);
    send(pk(3'h7, 4'h5, 4'h0, 3'h4, 4'h0, 8'h00), 2'h0);
    send(pk(3'h7, 4'h5, 4'h0, 3'h0, 4'h1, 8'h00), 2'h1);
    send(pk(3'h7, 4'h5, 4'h0, 3'h0, 4'h1, 8'h00), 2'h2);
    chkb("both copies bad", 1'b1, msg_rx_error);
  endtask
  task automatic t_msg_tx;
    for (int i = 0; i < 3; i++) begin
      pulse_xact();
      backend_fault = 1'b1;
      step(1);
      backend_fault = 1'b0;
      step(1);
      chkb("fatal", 1'b1, fatal_fault_flag);
      base = link_peer_inst.cnt;
      tx_msg_index = 4'(i);
      tx_msg_req = 1'b1;
      step(1);
      tx_msg_req = 1'b0;
      repeat (60) if (tx_msg_busy === 1'b1) step(1);
      chkb("msg busy", 1'b0, tx_msg_busy);
      step(8);
      chkw("copies", 30'h0000_0002, 30'(link_peer_inst.cnt - base));
      chkw("copy 1", pk(3'h7, 4'h0, 4'h5, 3'h0, 4'(i), 8'h80), link_peer_inst.got[base]);
      chkw("copy 2", pk(3'h7, 4'h0, 4'h5, 3'h0, 4'(i), 8'h80),
           link_peer_inst.got[base+1]);
      chkb("aborted", 1'b0, fatal_fault_flag);
    end
    // a corrupted packet must be reported once, in the next status message
    send(pk(3'h0, 4'h5, 4'h0, 3'h0, 4'h0, 8'h00), 2'h1);
    base = link_peer_inst.cnt;
    tx_msg_index = 4'h2;
    tx_msg_req = 1'b1;
    step(1);
    tx_msg_req = 1'b0;
    step(12);
    chkw("status copy", pk(3'h7, 4'h0, 4'h5, 3'h0, 4'h2, 8'h01),
         link_peer_inst.got[base+1]);
    chkb("retryable sent", 1'b0, retryable_fault_flag);
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    {srst, node_id_load, rx_valid, rx_crc_error, rx_frame_error} = 5'h10;
    {tx_msg_req, backend_fault, xact_cmd, mode} = 5'h00;
    {node_id_value, tx_msg_index, tx_msg_dest, tx_msg_tag} = 15'h0002;
    {rx_native_packet_flag, rx_packet_kind, rx_dest_node, rx_src_node, rx_transaction_tag,
      rx_message_category, rx_message_index, rx_message_code} = 30'h0000_0000;
    repeat (10) @(posedge clock);
    #1;
    srst = 1'b0;
    chkb("tx valid", 1'b0, tx_valid);
    t_node_id();
    t_local();
    t_forward();
    t_errors();
    t_msg_rx();
    mode = 2'h1;
    t_msg_tx();
    give_verdict();
  end
endmodule // testbench
bind pkt_link_handler link_checker link_checker_inst (.*);
